// >>> bench/mps_chk_sva.sv
`timescale 1ns/1ps
module mps_chk
   import mps_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Memories
   input wire logic [PC_W-1:0]   prog_addr,
   input wire logic              dm_we
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Wait-free slave
   property p_rdy; pready == ce; endproperty
   a_rdy: assert property (p_rdy) else $error("pready not equal to ce");
   // Error only in access phase
   property p_err_ph; pslverr |-> psel && penable; endproperty
   a_err_ph: assert property (p_err_ph) else $error("pslverr outside access");
   // Unmapped offset errors
   property p_err_map; psel && penable && paddr > REG_ACC |-> pslverr; endproperty
   a_err_map: assert property (p_err_map) else $error("no error on unmapped");
   // Mapped offsets never error
   property p_no_err; psel && penable && paddr <= REG_ACC && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
   a_no_err: assert property (p_no_err) else $error("error on mapped");
   // Fetch address stands a whole cycle
   property p_hold; ce && $changed(prog_addr) |=> $stable(prog_addr) [*3]; endproperty
   a_hold: assert property (p_hold) else $error("fetch address moved early");
   // Execution starts at reset vector
   property p_rst_vec; $rose(presetn) |-> prog_addr == RESET_VECTOR; endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("bad first fetch");
   // Write strobe is one isolated pulse
   property p_we; dm_we |=> !dm_we [*2]; endproperty
   a_we: assert property (p_we) else $error("write strobe too long");
   // Byte-wide registers
   property p_width; prdata[31:8] == 24'h000000; endproperty
   a_width: assert property (p_width) else $error("read data above byte");
   // Main scenarios
   c_wr: cover property (psel && penable && pready);
   c_we: cover property (dm_we);
   c_int: cover property (prog_addr == EXT_VECTOR);
endmodule
bind mps_sequencer mps_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .prog_addr, .dm_we);

// >>> bench/mps_mem_model.sv
`timescale 1ns/1ps
module mps_mem_model
   import mps_pkg::*;
(
   // Clock
   input  wire logic              pclk,
   // Program side
   input  wire logic [PC_W-1:0]   prog_addr,
   output logic      [WORD_W-1:0] prog_data,
   // Data side
   input  wire logic [DADR_W-1:0] dm_addr,
   input  wire logic [DATA_W-1:0] dm_wdata,
   input  wire logic              dm_we,
   output logic      [DATA_W-1:0] dm_rdata
);
   logic [WORD_W-1:0] rom [1024]; // Program words
   logic [DATA_W-1:0] ram [64];   // Data bytes
   // Unused words hold idle
   initial begin
      for (int i = 0; i < 1024; i++) rom[i] = IDLE_WORD;
      for (int i = 0; i < 64; i++) ram[i] = 8'h00;
   end
   // Asynchronous reads
   assign prog_data = rom[prog_addr];
   assign dm_rdata  = ram[dm_addr];
   // Byte write on strobe
   always @(posedge pclk) if (dm_we) ram[dm_addr] <= dm_wdata;
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import mps_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_int_pin = 0, timer_ovf = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, dm_we, er;
   logic [9:0]  prog_addr;
   logic [13:0] prog_data;
   logic [5:0]  dm_addr;
   logic [7:0]  dm_wdata, dm_rdata;
   int          error_cnt = 0, tests_run = 0;
   // Design and memories
   mps_sequencer dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .prog_addr, .prog_data, .dm_addr, .dm_wdata, .dm_we,
      .dm_rdata, .ext_int_pin, .timer_ovf);
   mps_mem_model mem_u (.pclk, .prog_addr, .prog_data, .dm_addr, .dm_wdata, .dm_we, .dm_rdata);
   // 100 MHz clock
   initial begin
      forever #5 pclk = ~pclk;
   end
   // Verdict
   task automatic end_sim;
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Value compare
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // One APB transfer, result in rd and er
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, 0);
      if (n >= 20) end_sim();
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Bounded wait for a fetch address
   task automatic wait_pc(logic [9:0] a);
      int n;
      n = 0;
      while (prog_addr !== a && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk("prog_addr", {22'h0, a}, {22'h0, prog_addr});
      if (prog_addr !== a) end_sim();
   endtask
   // Reset state
   task automatic t_reset;
      @(posedge pclk);
      chk("reset fetch", {22'h0, RESET_VECTOR}, {22'h0, prog_addr});
      apb(0, REG_CTRL, 0);
      chk("ctrl", {24'h0, CTRL_RESET}, rd);
      apb(1, REG_TBLP, 32'h05);
   endtask
   // Program run: ALU, call, return, table
   task automatic t_prog;
      wait_pc(10'h200);
      wait_pc(10'h102);
      repeat (12) @(posedge pclk);
      chk("sum", 8'h38, mem_u.ram[16]);
      chk("tbl low", 8'h5b, mem_u.ram[17]);
      apb(0, REG_STATUS, 0);
      chk("status", 32'h0b, rd);
      apb(0, REG_LOOKUP_HIGH_BYTE, 0);
      chk("tbl high", 32'h2a, rd);
      apb(1, REG_ACC, 32'hff);
      apb(0, REG_ACC, 0);
      chk("acc", 32'h9c, rd);
      apb(0, 12'h020, 0);
      chk("err", {31'h0, 1'b1}, {31'h0, er});
      chk("err data", 0, rd);
   endtask
   // Low byte write jumps in page
   task automatic t_pcl;
      apb(1, REG_PCL, 32'h80);
      wait_pc(10'h180);
      repeat (12) @(posedge pclk);
      apb(0, REG_ACC, 0);
      chk("skip acc", 32'h9c, rd);
   endtask
   // Rising pin edge enters vector
   task automatic t_int;
      apb(1, REG_CTRL, 32'h16);
      ext_int_pin <= 1;
      wait_pc(EXT_VECTOR);
   endtask
   // Timer overflow enters its vector; a full stack then holds the pin request
   task automatic t_tmr;
      apb(1, REG_CTRL, 32'h1f);
      timer_ovf <= 1;
      @(posedge pclk);
      timer_ovf <= 0;
      wait_pc(TMR_VECTOR);
      ext_int_pin <= 0;
      repeat (16) @(posedge pclk);
      apb(0, REG_STATUS, 0);
      chk("held request", 32'h1b, rd);
   endtask
   // Main sequence
   initial begin
      #1;
      mem_u.rom[0] = 14'h289c;
      mem_u.rom[1] = 14'h2210;
      mem_u.rom[2] = 14'h0050;
      mem_u.rom[3] = 14'h1100;
      mem_u.rom[4] = 14'h1004;
      mem_u.rom[10'h100] = 14'h1a00;
      mem_u.rom[10'h101] = 14'h2111;
      mem_u.rom[10'h103] = 14'h1102;
      mem_u.rom[10'h105] = 14'h2a5b;
      mem_u.rom[10'h180] = 14'h0820;
      mem_u.rom[10'h181] = 14'h2877;
      mem_u.rom[10'h182] = 14'h1180;
      mem_u.rom[10'h200] = 14'h2000;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_prog();
      t_pcl();
      t_int();
      t_tmr();
      end_sim();
   end
endmodule

// >>> logic/mps_pkg.sv
package mps_pkg;
   // Widths
   localparam int PC_W   = 10;
   localparam int WORD_W = 14;
   localparam int DATA_W = 8;
   localparam int DADR_W = 6;

   // Register byte offsets
   localparam logic [11:0] REG_PCL    = 12'h000;
   localparam logic [11:0] REG_CTRL   = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_TBLP   = 12'h00c;
   localparam logic [11:0] REG_LOOKUP_HIGH_BYTE   = 12'h010;
   localparam logic [11:0] REG_ACC    = 12'h014;

   // Control register one fields and reset value
   localparam int CTRL_EDGE_LSB = 0;
   localparam int CTRL_EXT_EN   = 2;
   localparam int CTRL_TMR_EN   = 3;
   localparam int CTRL_RUN      = 4;
   localparam logic [7:0] CTRL_RESET = 8'h10;

   // Status register fields
   localparam int ST_C       = 0;
   localparam int ST_AC      = 1;
   localparam int ST_Z       = 2;
   localparam int ST_OV      = 3;
   localparam int ST_EXT_REQ = 4;
   localparam int ST_TMR_REQ = 5;

   // Special vectors
   localparam logic [9:0] RESET_VECTOR = 10'h000;
   localparam logic [9:0] EXT_VECTOR   = 10'h004;
   localparam logic [9:0] TMR_VECTOR   = 10'h008;

   // Stack depth and idle word
   localparam logic [1:0]  STACK_DEPTH = 2'h2;
   localparam logic [13:0] IDLE_WORD   = 14'h3800;
   localparam logic [1:0]  LAST_PAGE   = 2'h3;

   // One-hot phase clocks
   typedef enum logic [3:0] {
      PH1 = 4'b0001,
      PH2 = 4'b0010,
      PH3 = 4'b0100,
      PH4 = 4'b1000
   } mps_phase_t;

   // Instruction classes in bits 13:11
   typedef enum logic [2:0] {
      CL_ALU  = 3'h0,
      CL_SKIP = 3'h1,
      CL_JMP  = 3'h2,
      CL_CALL = 3'h3,
      CL_MISC = 3'h4,
      CL_LDI  = 3'h5
   } mps_class_t;

   // Operations of the arithmetic unit
   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
      ALU_AND = 4'h4, ALU_OR  = 4'h5, ALU_XOR = 4'h6, ALU_CPL = 4'h7,
      ALU_RR  = 4'h8, ALU_RRC = 4'h9, ALU_RL  = 4'ha, ALU_RLC = 4'hb,
      ALU_INC = 4'hc, ALU_DEC = 4'hd, ALU_DAA = 4'he, ALU_MOV = 4'hf
   } mps_alu_t;
endpackage

// >>> logic/mps_sequencer.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
// Contract
// - four phases form one instruction cycle
// - PC advances at phase one; execute later
// - fetch overlaps execute; branches take two
// - taken skip discards prefetch, runs dummy
// - ten-bit PC, low byte software visible
// - low byte write jumps in page
// - branches, interrupts, reset load PC directly
// - two-level hidden return stack
// - call/interrupt push, returns pop
// - reset leaves stack empty
// - full stack withholds interrupt acknowledge
// - call on full stack overflows unguarded
// - ALU arithmetic, logic, rotate, inc, dec
// - ALU outcomes except RR and RL update status flags
// - PC addresses 1k by 14 memory
// - reset starts at fixed vector
// - selected pin edge enters external vector
// - timer overflow enters timer vector
// - table read: pointer address, two bytes
// - unbacked high table bits read zero
// - current page or last page table
// - table reads take two cycles
// - eight-bit data path
module mps_sequencer
   import mps_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Program memory
   output logic      [PC_W-1:0]     prog_addr,
   input  wire logic [WORD_W-1:0]   prog_data,
   // Data memory
   output logic      [DADR_W-1:0]   dm_addr,
   output logic      [DATA_W-1:0]   dm_wdata,
   output logic                     dm_we,
   input  wire logic [DATA_W-1:0]   dm_rdata,
   // Interrupt sources
   input  wire logic                ext_int_pin,
   input  wire logic                timer_ovf
);

   mps_phase_t          phase;          // Current phase clock
   logic [PC_W-1:0]     pc;             // Program counter
   logic [PC_W-1:0]     stack [2];      // Return stack
   logic [1:0]          stack_ptr;      // Levels in use
   logic [WORD_W-1:0]   fetch_word;     // Prefetched instruction
   logic [WORD_W-1:0]   exec_word;      // Instruction in execution
   logic                exec_valid;     // Low for a dummy cycle
   logic                tbl_cycle;      // Second cycle of a table read
   logic [PC_W-1:0]     tbl_addr;       // Table word address
   logic [DADR_W-1:0]   tbl_dest;       // Table low byte destination
   logic [DATA_W-1:0]   acc;            // Accumulator
   logic [DATA_W-1:0]   operand;        // Data memory operand
   logic [3:0]          flags;          // C, AC, Z, OV
   logic [7:0]          ctrl;           // Control register one
   logic [DATA_W-1:0]   tblp;           // Table pointer
   logic [DATA_W-1:0]   lookup_high_byte; // Upper table bits
   logic                pcl_pend;       // Pending low byte write
   logic [DATA_W-1:0]   pcl_data;       // Value to load
   logic                ext_req;        // External request flag
   logic                tmr_req;        // Timer request flag
   logic [2:0]          pin_sync;       // Pin synchroniser and history

   // Decoded fields
   mps_class_t          op_class;
   logic [3:0]          op_sub;
   logic                op_dest;
   logic [DADR_W-1:0]   op_addr;

   // Execute results
   logic                redirect;
   logic [PC_W-1:0]     next_fetch;
   logic                do_push;
   logic                do_pop;
   logic                int_ack;
   logic                pcl_take;       // Pending low byte jump taken now
   logic                ack_ext;
   logic                tbl_start;
   logic                acc_we;
   logic                mem_we;
   logic [DATA_W-1:0]   result;
   logic [3:0]          next_flags;
   logic [14:0]         alu_out;
   logic                stack_full;
   logic                apb_wr;
   logic                pin_rise;
   logic                pin_fall;

   // Arithmetic unit: returns {update mask C AC OV Z, C, AC, OV, result}
   function automatic logic [14:0] alu_calc(input logic [3:0] op, input logic [7:0] a,
                                            input logic [7:0] m, input logic ci, input logic aci);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] b;
      logic [7:0] r;
      logic       cin;
      logic       co;
      logic       ao;
      logic       vo;
      logic [3:0] u;
      begin
         s   = 9'h000;
         h   = 5'h00;
         b   = m;
         r   = 8'h00;
         cin = 1'b0;
         co  = ci;
         ao  = aci;
         vo  = 1'b0;
         u   = 4'b0001;
         case (op)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
               // Subtract adds the complement; carry high means no borrow
               b   = (op == ALU_SUB || op == ALU_SBC) ? ~m : m;
               cin = (op == ALU_SUB) ? 1'b1 : ((op == ALU_ADD) ? 1'b0 : ci);
               s   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
               h   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
               r   = s[7:0];
               co  = s[8];
               ao  = h[4];
               vo  = (a[7] == b[7]) && (r[7] != a[7]);
               u   = 4'b1111;
            end
            ALU_AND: r = a & m;
            ALU_OR:  r = a | m;
            ALU_XOR: r = a ^ m;
            ALU_CPL: r = ~m;
            ALU_RR: begin
               r = {m[0], m[7:1]};
               u = 4'b0000;
            end
            ALU_RRC: begin
               r  = {ci, m[7:1]};
               co = m[0];
               u  = 4'b1000;
            end
            ALU_RL: begin
               r = {m[6:0], m[7]};
               u = 4'b0000;
            end
            ALU_RLC: begin
               r  = {m[6:0], ci};
               co = m[7];
               u  = 4'b1000;
            end
            ALU_INC: r = m + 8'h01;
            ALU_DEC: r = m - 8'h01;
            ALU_DAA: begin
               // Decimal adjust of the accumulator
               b  = {((a > 8'h99) || ci) ? 4'h6 : 4'h0, ((a[3:0] > 4'h9) || aci) ? 4'h6 : 4'h0};
               s  = {1'b0, a} + {1'b0, b};
               r  = s[7:0];
               co = ci | s[8] | (a > 8'h99);
               u  = 4'b1000;
            end
            default: r = m;
         endcase
         alu_calc = {u, co, ao, vo, r};
      end
   endfunction

   // Field decode of the executing instruction
   assign op_class   = mps_class_t'(exec_word[13:11]);
   assign op_sub     = exec_word[10:7];
   assign op_dest    = exec_word[6];
   assign op_addr    = exec_word[5:0];
   assign stack_full = (stack_ptr >= STACK_DEPTH);
   assign alu_out    = alu_calc(op_sub, acc, operand, flags[ST_C], flags[ST_AC]);
   assign apb_wr     = ce && psel && penable && pwrite;
   assign pin_rise   = pin_sync[1] && !pin_sync[2];
   assign pin_fall   = !pin_sync[1] && pin_sync[2];

   // Execute decision, valid at the end of the fourth phase
   always_comb begin
      redirect   = 1'b0;
      next_fetch = pc;
      do_push    = 1'b0;
      do_pop     = 1'b0;
      int_ack    = 1'b0;
      pcl_take   = 1'b0;
      ack_ext    = 1'b0;
      tbl_start  = 1'b0;
      acc_we     = 1'b0;
      mem_we     = 1'b0;
      result     = alu_out[7:0];
      next_flags = flags;
      if (exec_valid) begin
         case (op_class)
            CL_ALU: begin
               // Result to accumulator or memory, eight bits wide
               acc_we = !op_dest;
               mem_we = op_dest;
               if (alu_out[14]) next_flags[ST_C]  = alu_out[10];
               if (alu_out[13]) next_flags[ST_AC] = alu_out[9];
               if (alu_out[12]) next_flags[ST_OV] = alu_out[8];
               if (alu_out[11]) next_flags[ST_Z]  = (alu_out[7:0] == 8'h00);
            end
            CL_SKIP: begin
               // Skip decision; increment or decrement forms also write
               result = op_sub[1] ? (op_sub[0] ? operand - 8'h01 : operand + 8'h01) : operand;
               acc_we = op_sub[1] && op_dest;
               mem_we = op_sub[1] && !op_dest;
               if ((result == 8'h00) != (op_sub[1:0] == 2'b01)) begin
                  redirect = 1'b1;
               end
            end
            CL_JMP: begin
               redirect   = 1'b1;
               next_fetch = exec_word[9:0];
            end
            CL_CALL: begin
               // No guard on a full stack: the push wraps
               redirect   = 1'b1;
               do_push    = 1'b1;
               next_fetch = exec_word[9:0];
            end
            CL_MISC: begin
               if (op_sub[2:1] == 2'b00) begin
                  // Either return form pops the saved address
                  redirect   = 1'b1;
                  do_pop     = 1'b1;
                  next_fetch = stack[stack_ptr[0] ^ 1'b1];
               end else if (op_sub[2:1] == 2'b01) begin
                  tbl_start = 1'b1;
               end else if (op_sub[2:0] == 3'b100) begin
                  mem_we = 1'b1;
                  result = acc;
               end
            end
            CL_LDI: begin
               acc_we = 1'b1;
               result = exec_word[7:0];
            end
            default: ;
         endcase
      end
      // Software write of the low byte: jump within the page
      if (!redirect && !tbl_start && pcl_pend) begin
         redirect   = 1'b1;
         pcl_take   = 1'b1;
         next_fetch = {pc[9:8], pcl_data};
      end
      // Interrupt acknowledge only with a free stack level
      if (!redirect && !tbl_start && !tbl_cycle && !stack_full) begin
         if (ext_req && ctrl[CTRL_EXT_EN]) begin
            int_ack    = 1'b1;
            ack_ext    = 1'b1;
            next_fetch = EXT_VECTOR;
         end else if (tmr_req && ctrl[CTRL_TMR_EN]) begin
            int_ack    = 1'b1;
            next_fetch = TMR_VECTOR;
         end
         redirect = int_ack;
         do_push  = int_ack;
      end
   end

   // Phase clock generator, halted while run is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= PH1;
      end else if (ce && ctrl[CTRL_RUN]) begin
         case (phase)
            PH1:     phase <= PH2;
            PH2:     phase <= PH3;
            PH3:     phase <= PH4;
            default: phase <= PH1;
         endcase
      end
   end

   // Program counter and fetch address; the counter moves on as phase one begins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc        <= RESET_VECTOR + 10'h001;
         prog_addr <= RESET_VECTOR;
      end else if (ce && ctrl[CTRL_RUN] && phase == PH4) begin
         if (tbl_start) begin
            prog_addr <= tbl_addr;
         end else begin
            prog_addr <= next_fetch;
            pc        <= next_fetch + 10'h001;
         end
      end
   end

   // Table address: current page or last page
   always_comb begin
      tbl_addr = op_sub[0] ? {LAST_PAGE, tblp} : {pc[9:8], tblp};
   end

   // Prefetch and execute slots of the pipeline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_word <= IDLE_WORD;
         exec_word  <= IDLE_WORD;
         exec_valid <= 1'b0;
         tbl_cycle  <= 1'b0;
         tbl_dest   <= '0;
      end else if (ce && ctrl[CTRL_RUN]) begin
         if (phase == PH1 && !tbl_cycle) begin
            fetch_word <= prog_data;
         end
         if (phase == PH4) begin
            // A redirect discards the prefetched word
            exec_word  <= fetch_word;
            exec_valid <= !redirect && !tbl_start;
            tbl_cycle  <= tbl_start;
            if (tbl_start) tbl_dest <= op_addr;
         end
      end
   end

   // Return stack, hidden from software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_ptr <= 2'h0;
         stack[0]  <= '0;
         stack[1]  <= '0;
      end else if (ce && ctrl[CTRL_RUN] && phase == PH4) begin
         if (do_push) begin
            stack[stack_ptr[0]] <= pc - 10'h001;
            stack_ptr           <= stack_ptr + 2'h1;
         end else if (do_pop && stack_ptr != 2'h0) begin
            stack_ptr <= stack_ptr - 2'h1;
         end
      end
   end

   // Accumulator, status flags and operand capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc     <= '0;
         flags   <= '0;
         operand <= '0;
      end else if (ce && ctrl[CTRL_RUN]) begin
         if (phase == PH3) operand <= dm_rdata;
         if (phase == PH4) begin
            flags <= next_flags;
            if (acc_we) acc <= result;
         end
      end
   end

   // Data memory port: operand address, result or table byte writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dm_addr  <= '0;
         dm_wdata <= '0;
         dm_we    <= 1'b0;
      end else if (ce) begin
         dm_we <= 1'b0;
         if (ctrl[CTRL_RUN] && phase == PH1) begin
            if (tbl_cycle) begin
               dm_addr  <= tbl_dest;
               dm_wdata <= prog_data[7:0];
               dm_we    <= 1'b1;
            end else begin
               dm_addr <= op_addr;
            end
         end else if (ctrl[CTRL_RUN] && phase == PH4 && mem_we) begin
            dm_wdata <= result;
            dm_we    <= 1'b1;
         end
      end
   end

   // Upper table bits with no memory behind them are zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lookup_high_byte <= '0;
      end else if (ce && ctrl[CTRL_RUN] && phase == PH1 && tbl_cycle) begin
         lookup_high_byte <= {2'b00, prog_data[13:8]};
      end
   end

   // Pin synchroniser, then edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 3'h0;
      end else if (ce) begin
         pin_sync <= {pin_sync[1:0], ext_int_pin};
      end
   end

   // Request flags: a new event wins over the acknowledge clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_req <= 1'b0;
         tmr_req <= 1'b0;
      end else if (ce) begin
         if ((pin_rise && ctrl[CTRL_EDGE_LSB+1]) || (pin_fall && ctrl[CTRL_EDGE_LSB])) begin
            ext_req <= 1'b1;
         end else if (int_ack && ack_ext && ctrl[CTRL_RUN] && phase == PH4) begin
            ext_req <= 1'b0;
         end
         if (timer_ovf) begin
            tmr_req <= 1'b1;
         end else if (int_ack && !ack_ext && ctrl[CTRL_RUN] && phase == PH4) begin
            tmr_req <= 1'b0;
         end
      end
   end

   // Software registers and pending low byte jump
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= CTRL_RESET;
         tblp     <= '0;
         pcl_pend <= 1'b0;
         pcl_data <= '0;
      end else if (ce) begin
         // Cleared only once the page jump itself is taken, not by a branch of the program
         if (pcl_take && ctrl[CTRL_RUN] && phase == PH4) begin
            pcl_pend <= 1'b0;
         end
         if (apb_wr) begin
            if (paddr == REG_PCL) begin
               pcl_pend <= 1'b1;
               pcl_data <= pwdata[7:0];
            end else if (paddr == REG_CTRL) begin
               ctrl <= pwdata[7:0];
            end else if (paddr == REG_TBLP) begin
               tblp <= pwdata[7:0];
            end
         end
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (ce && psel && !penable) begin
         prdata <= '0;
         if (paddr == REG_PCL) begin
            prdata[7:0] <= pc[7:0];
         end else if (paddr == REG_CTRL) begin
            prdata[7:0] <= ctrl;
         end else if (paddr == REG_STATUS) begin
            prdata[5:0] <= {tmr_req, ext_req, flags};
         end else if (paddr == REG_TBLP) begin
            prdata[7:0] <= tblp;
         end else if (paddr == REG_LOOKUP_HIGH_BYTE) begin
            prdata[7:0] <= lookup_high_byte;
         end else if (paddr == REG_ACC) begin
            prdata[7:0] <= acc;
         end
      end
   end

   // Ready follows the clock enable; unmapped offsets answer with an error
   assign pready  = ce;
   assign pslverr = psel && penable && !(paddr == REG_PCL || paddr == REG_CTRL || paddr == REG_STATUS ||
                                          paddr == REG_TBLP || paddr == REG_LOOKUP_HIGH_BYTE || paddr == REG_ACC);

endmodule
